//--- common/fagen_pkg.sv
package fagen_pkg;

  // ==========================================================================
  // fixed-point formats
  localparam int XY_W = 16;
  localparam int FRAC_W = 4;
  localparam int HEIGHT_W = 12;
  localparam int FC_W = 18;
  localparam logic [FC_W-1:0] FC_HALF = 18'h00008;
  localparam int DEPTH_W = 25;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 25'h1000000;
  localparam int DEPTH_FRAC = 24;
  localparam int SDEPTH_W = 32;
  localparam int W_W = 32;
  localparam int DIV_W = 33;
  localparam logic [5:0] DIV_LAST = 6'h20;
  localparam int NSAMP = 8;
  localparam int SMASK_W = 32;
  localparam int SID_W = 3;
  localparam int SCNT_W = 4;
  localparam int SPOS_W = 9;
  localparam logic [SPOS_W-1:0] SPOS_HALF = 9'h080;
  localparam int PRIM_W = 32;
  localparam int COL_W = 32;
  localparam int NCOL = 4;
  localparam int COL_FRAC = 16;
  localparam logic [COL_W-1:0] COL_ONE = 32'h00010000;
  localparam logic [COL_W-1:0] COL_ROUND = 32'h00008000;
  localparam logic [COL_W-1:0] UNORM8_MAX = 32'h000000ff;
  localparam logic [COL_W-1:0] SNORM8_MAX = 32'h0000007f;

  // ==========================================================================
  // register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_HEIGHT = 12'h004;
  localparam logic [ADDR_W-1:0] REG_SAMPLES = 12'h008;
  localparam logic [ADDR_W-1:0] REG_PRIMCNT = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h010;
  localparam int CB_PIX_INT = 0;
  localparam int CB_UPPER_LEFT = 1;
  localparam int CB_WIND_REV = 2;
  localparam int CB_MS_EN = 3;
  localparam int CB_GS_ACT = 4;
  localparam int CB_DEPTH_FIX = 5;
  localparam int CB_SHD_DEPTH = 6;
  localparam int CB_PER_SAMPLE = 7;
  localparam int CB_COLFMT = 8;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h028;
  localparam logic [HEIGHT_W-1:0] HEIGHT_RESET = 12'h000;
  localparam logic [SCNT_W-1:0] SAMPLES_RESET = 4'h1;

  typedef enum logic [1:0] {
    COL_PASS = 2'b00,
    COL_UNORM = 2'b01,
    COL_SNORM = 2'b10
  } fagen_colfmt_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV = 2'b01,
    ST_OUT = 2'b11
  } fagen_state_e;

  typedef struct packed {
    logic [XY_W-1:0] x_w;
    logic [XY_W-1:0] y_w;
    logic [DEPTH_W-1:0] z_w;
    logic [W_W-1:0] w_c;
    logic is_tri;
    logic area_pos;
    logic [PRIM_W-1:0] gs_prim;
    logic [NSAMP-1:0] cov;
    logic [NSAMP-1:0] keep;
    logic [NSAMP-1:0] inv;
    logic [SID_W-1:0] sample_num;
    logic [SPOS_W-1:0] spos_x;
    logic [SPOS_W-1:0] spos_y;
  } fagen_frag_s;

  typedef struct packed {
    logic signed [FC_W-1:0] fc_x;
    logic signed [FC_W-1:0] fc_y;
    logic [DEPTH_W-1:0] fc_z;
    logic [W_W-1:0] w_recip;
    logic front;
    logic [PRIM_W-1:0] prim_idx;
    logic [SMASK_W-1:0] mask_in;
    logic [SID_W-1:0] sample_id;
    logic [SCNT_W-1:0] sample_cnt;
    logic [SPOS_W-1:0] spos_x;
    logic [SPOS_W-1:0] spos_y;
  } fagen_attr_s;

  typedef struct packed {
    logic signed [SDEPTH_W-1:0] depth;
    logic [SMASK_W-1:0] cov_out;
    logic [SMASK_W-1:0] mask_in;
    logic [DEPTH_W-1:0] rast_depth;
    logic [NCOL-1:0][COL_W-1:0] color;
  } fagen_res_s;

  typedef struct packed {
    logic [DEPTH_W-1:0] depth;
    logic [SMASK_W-1:0] cov;
    logic [NCOL-1:0][COL_W-1:0] color;
  } fagen_post_s;

endpackage : fagen_pkg

//--- rtl/fagen_top.sv
// The placing of the registers and register access over APB were decided locally.
module fagen_top
  import fagen_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_DRAW_START,
  input wire logic I_PRIM_DONE,
  input wire logic I_PRIM_RESTART,
  input wire logic I_FRAG_VALID,
  output logic O_FRAG_READY,
  input wire fagen_frag_s I_FRAG,
  output logic O_ATTR_VALID,
  input wire logic I_ATTR_READY,
  output fagen_attr_s O_ATTR,
  input wire logic I_RES_VALID,
  output logic O_RES_READY,
  input wire fagen_res_s I_RES,
  output logic O_POST_VALID,
  input wire logic I_POST_READY,
  output fagen_post_s O_POST
);

  // ==========================================================================
  // functions
  function automatic logic signed [FC_W-1:0] centre_adj(input logic signed [FC_W-1:0] v,
                                                        input logic pix_int);
    centre_adj = pix_int ? v - $signed(FC_HALF) : v;
  endfunction : centre_adj

  function automatic logic [DEPTH_W-1:0] conv_depth(input logic signed [SDEPTH_W-1:0] d,
                                                    input logic fixed);
    logic [DEPTH_W-1:0] c;
    c = '0;
    if (d[SDEPTH_W-1]) begin
      c = '0;
    end else if (d >= $signed({7'h00, DEPTH_ONE})) begin
      c = DEPTH_ONE;
    end else begin
      c = d[DEPTH_W-1:0];
    end
    // scale 0..1 onto 0..2^24-1 without a depth-range step
    conv_depth = fixed ? c - (c >> DEPTH_FRAC) : c;
  endfunction : conv_depth

  function automatic logic [COL_W-1:0] conv_color(input logic signed [COL_W-1:0] v,
                                                  input logic [1:0] fmt);
    logic [COL_W-1:0] mag;
    logic [COL_W-1:0] r;
    mag = v[COL_W-1] ? COL_W'(-v) : v;
    r = '0;
    case (fmt)
      COL_UNORM: begin
        if (v[COL_W-1]) begin
          r = '0;
        end else if (mag >= COL_ONE) begin
          r = UNORM8_MAX;
        end else begin
          r = (mag * UNORM8_MAX + COL_ROUND) >> COL_FRAC;
        end
      end
      COL_SNORM: begin
        if (mag >= COL_ONE) begin
          r = SNORM8_MAX;
        end else begin
          r = (mag * SNORM8_MAX + COL_ROUND) >> COL_FRAC;
        end
        if (v[COL_W-1]) begin
          r = COL_W'(-r);
        end
      end
      default: begin
        r = v;
      end
    endcase
    conv_color = r;
  endfunction : conv_color

  // ==========================================================================
  // register file
  logic [CTRL_W-1:0] ctrl_reg;
  logic [HEIGHT_W-1:0] height_reg;
  logic [SCNT_W-1:0] samples_reg;
  logic [PRIM_W-1:0] prim_cnt_reg;
  fagen_state_e state_reg;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rdata;

  assign setup = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE & O_PREADY;
  assign mapped = (I_PADDR == REG_CTRL) || (I_PADDR == REG_HEIGHT) ||
                  (I_PADDR == REG_SAMPLES) || (I_PADDR == REG_PRIMCNT) ||
                  (I_PADDR == REG_STATUS);

  always_comb begin
    rdata = '0;
    case (I_PADDR)
      REG_CTRL: rdata = 32'(ctrl_reg);
      REG_HEIGHT: rdata = 32'(height_reg);
      REG_SAMPLES: rdata = 32'(samples_reg);
      REG_PRIMCNT: rdata = prim_cnt_reg;
      REG_STATUS: rdata = {29'h0, O_POST_VALID, O_ATTR_VALID, state_reg != ST_IDLE};
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= '0;
      O_PSLVERR <= 1'b0;
    end else if (I_CE) begin
      O_PREADY <= setup;
      if (setup) begin
        O_PRDATA <= rdata;
        O_PSLVERR <= ~mapped;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_reg <= CTRL_RESET;
      height_reg <= HEIGHT_RESET;
      samples_reg <= SAMPLES_RESET;
    end else if (I_CE && access && I_PWRITE) begin
      case (I_PADDR)
        REG_CTRL: ctrl_reg <= I_PWDATA[CTRL_W-1:0];
        REG_HEIGHT: height_reg <= I_PWDATA[HEIGHT_W-1:0];
        REG_SAMPLES: samples_reg <= I_PWDATA[SCNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // primitive counter
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      prim_cnt_reg <= '0;
    end else if (I_CE) begin
      if (I_DRAW_START) begin
        prim_cnt_reg <= '0;
      end else if (I_PRIM_DONE) begin
        // one pulse per polygon, restart pulses never count
        prim_cnt_reg <= prim_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // fragment attributes
  logic ms_on;
  logic [NSAMP-1:0] live;
  logic [NSAMP-1:0] own;
  logic [SMASK_W-1:0] mask_next;
  logic signed [FC_W-1:0] y_flip;
  fagen_attr_s attr_next;
  fagen_frag_s frag_q;
  logic accept;

  assign ms_on = ctrl_reg[CB_MS_EN] && (samples_reg > SAMPLES_RESET);
  assign live = I_FRAG.cov & I_FRAG.keep;
  assign own = ctrl_reg[CB_PER_SAMPLE] ? NSAMP'(1) << I_FRAG.sample_num : I_FRAG.inv;
  assign accept = I_FRAG_VALID & O_FRAG_READY;

  always_comb begin
    if (!ms_on) begin
      mask_next = SMASK_W'(|I_FRAG.cov);
    end else begin
      mask_next = SMASK_W'(live & own);
    end
  end

  always_comb begin
    if (ctrl_reg[CB_UPPER_LEFT]) begin
      y_flip = $signed({2'b00, height_reg, {FRAC_W{1'b0}}}) - $signed({2'b00, I_FRAG.y_w});
    end else begin
      y_flip = $signed({2'b00, I_FRAG.y_w});
    end
    attr_next = '0;
    attr_next.fc_x = centre_adj($signed({2'b00, I_FRAG.x_w}), ctrl_reg[CB_PIX_INT]);
    attr_next.fc_y = centre_adj(y_flip, ctrl_reg[CB_PIX_INT]);
    attr_next.fc_z = I_FRAG.z_w;
    attr_next.front = ~I_FRAG.is_tri | (I_FRAG.area_pos ^ ctrl_reg[CB_WIND_REV]);
    attr_next.prim_idx = ctrl_reg[CB_GS_ACT] ? I_FRAG.gs_prim : prim_cnt_reg;
    attr_next.mask_in = mask_next;
    attr_next.sample_id = ms_on ? I_FRAG.sample_num : '0;
    attr_next.sample_cnt = samples_reg;
    attr_next.spos_x = ms_on ? I_FRAG.spos_x : SPOS_HALF;
    attr_next.spos_y = ms_on ? I_FRAG.spos_y : SPOS_HALF;
  end

  // ==========================================================================
  // reciprocal w divider and handshake
  logic [DIV_W-1:0] rem_reg;
  logic [DIV_W-1:0] quot_reg;
  logic [5:0] div_cnt_reg;
  logic [DIV_W-1:0] rem_shift;
  logic fit;

  assign rem_shift = {rem_reg[DIV_W-2:0], div_cnt_reg == '0};
  assign fit = rem_shift >= {1'b0, frag_q.w_c};

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_reg <= ST_IDLE;
      O_FRAG_READY <= 1'b0;
      O_ATTR_VALID <= 1'b0;
      O_ATTR <= '0;
      frag_q <= '0;
      rem_reg <= '0;
      quot_reg <= '0;
      div_cnt_reg <= '0;
    end else if (I_CE) begin
      case (state_reg)
        ST_IDLE: begin
          O_FRAG_READY <= ~accept;
          if (accept) begin
            O_ATTR <= attr_next;
            frag_q <= I_FRAG;
            rem_reg <= '0;
            quot_reg <= '0;
            div_cnt_reg <= '0;
            state_reg <= ST_DIV;
          end
        end
        ST_DIV: begin
          rem_reg <= fit ? rem_shift - {1'b0, frag_q.w_c} : rem_shift;
          quot_reg <= {quot_reg[DIV_W-2:0], fit};
          div_cnt_reg <= div_cnt_reg + 1'b1;
          if (div_cnt_reg == DIV_LAST) begin
            // saturate when 1/w exceeds the format, including w of zero
            O_ATTR.w_recip <= quot_reg[DIV_W-2] ? '1 : {quot_reg[DIV_W-3:0], fit};
            O_ATTR_VALID <= 1'b1;
            state_reg <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (I_ATTR_READY) begin
            O_ATTR_VALID <= 1'b0;
            O_FRAG_READY <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // shader output post-processing
  fagen_post_s post_next;

  always_comb begin
    post_next = '0;
    if (ctrl_reg[CB_SHD_DEPTH]) begin
      post_next.depth = conv_depth(I_RES.depth, ctrl_reg[CB_DEPTH_FIX]);
    end else begin
      post_next.depth = I_RES.rast_depth;
    end
    post_next.cov = I_RES.mask_in & I_RES.cov_out;
    for (int i = 0; i < NCOL; i++) begin
      post_next.color[i] = conv_color(I_RES.color[i], ctrl_reg[CB_COLFMT +: 2]);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_RES_READY <= 1'b0;
      O_POST_VALID <= 1'b0;
      O_POST <= '0;
    end else if (I_CE) begin
      if (I_RES_VALID && O_RES_READY) begin
        O_POST <= post_next;
        O_POST_VALID <= 1'b1;
        O_RES_READY <= 1'b0;
      end else if (O_POST_VALID && I_POST_READY) begin
        O_POST_VALID <= 1'b0;
        O_RES_READY <= 1'b1;
      end else if (!O_POST_VALID) begin
        O_RES_READY <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  logic signed [FC_W-1:0] x_ref;
  logic [63:0] prod_lo;
  logic [63:0] prod_hi;
  assign x_ref = $signed({2'b00, frag_q.x_w});
  assign prod_lo = 64'(O_ATTR.w_recip) * 64'(frag_q.w_c);
  assign prod_hi = prod_lo + 64'(frag_q.w_c);

  fc_x_a: assert property (O_ATTR_VALID |->
    O_ATTR.fc_x == (ctrl_reg[CB_PIX_INT] ? x_ref - $signed(FC_HALF) : x_ref))
    else $error("fragment x wrong");
  depth_pass_a: assert property (O_ATTR_VALID |-> O_ATTR.fc_z == frag_q.z_w)
    else $error("fragment z differs from window depth");
  recip_a: assert property (O_ATTR_VALID && frag_q.w_c != '0 && O_ATTR.w_recip != '1 |->
    prod_lo <= 64'h100000000 && prod_hi > 64'h100000000)
    else $error("reciprocal w out of tolerance");
  div_lat_a: assert property (accept && I_CE |-> ##[34:1000] O_ATTR_VALID)
    else $error("attributes never delivered");
  front_a: assert property (O_ATTR_VALID && !frag_q.is_tri |-> O_ATTR.front)
    else $error("non-triangle marked back-facing");
  prim_clr_a: assert property (I_CE && I_DRAW_START |=> prim_cnt_reg == '0)
    else $error("counter not cleared at draw");
  prim_inc_a: assert property (I_CE && I_PRIM_DONE && !I_DRAW_START |=>
    prim_cnt_reg == $past(prim_cnt_reg) + 1)
    else $error("counter did not advance");
  restart_a: assert property (I_PRIM_RESTART && !I_PRIM_DONE && !I_DRAW_START |=>
    $stable(prim_cnt_reg))
    else $error("restart moved the counter");
  mask_ss_a: assert property (O_ATTR_VALID && !ms_on |->
    O_ATTR.mask_in[SMASK_W-1:1] == '0 && O_ATTR.sample_id == '0)
    else $error("single-sample mask or id wrong");
  mask_kill_a: assert property (O_ATTR_VALID && ms_on |->
    (O_ATTR.mask_in[NSAMP-1:0] & ~(frag_q.cov & frag_q.keep)) == '0)
    else $error("killed sample left in mask");
  depth_clamp_a: assert property (O_POST_VALID |-> O_POST.depth <= DEPTH_ONE)
    else $error("depth above one");
  cov_sub_a: assert property (I_RES_VALID && O_RES_READY |=>
    (O_POST.cov & ~$past(I_RES.mask_in)) == '0)
    else $error("output mask added a sample");

  frag_flow_c: cover property (accept ##[1:100] (O_ATTR_VALID && I_ATTR_READY));
  post_flow_c: cover property (I_RES_VALID && O_RES_READY ##1 O_POST_VALID && I_POST_READY);
  ms_frag_c: cover property (accept && ms_on && ctrl_reg[CB_PER_SAMPLE]);

endmodule : fagen_top

//--- test/fagen_peer.sv
// ============================================================================
// rasterizer-side fragment source and shader-side attribute sink
module fagen_peer
  import fagen_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_send,
  input wire fagen_frag_s i_frag,
  input wire logic [3:0] i_stall,
  input wire logic i_frag_ready,
  output logic o_frag_valid = 1'b0,
  output fagen_frag_s o_frag = '0,
  input wire logic i_attr_valid,
  output logic o_attr_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt = 4'h0;

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_frag_valid <= 1'b0;
    end else if (i_send) begin
      o_frag_valid <= 1'b1;
      o_frag <= i_frag;
    end else if (o_frag_valid && i_frag_ready) begin
      o_frag_valid <= 1'b0;
      // released bus shows no stale data
      o_frag <= ~o_frag;
    end
  end

  // sink stalls i_stall cycles into each attribute word
  always @(posedge i_clk) begin
    if (i_srst || !i_attr_valid) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt != 4'hf) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  assign o_attr_ready = (wait_cnt >= i_stall);
endmodule : fagen_peer

//--- test/fagen_top_tb.sv
module fagen_top_tb
  import fagen_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic I_CLK, I_SRST, I_CE, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR;
  logic [ADDR_W-1:0] I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA, rdat;
  logic I_DRAW_START, I_PRIM_DONE, I_PRIM_RESTART, frag_valid, O_FRAG_READY, rerr;
  logic O_ATTR_VALID, attr_ready, I_RES_VALID, O_RES_READY, O_POST_VALID, I_POST_READY, snd;
  logic [3:0] stall;
  fagen_frag_s frag_bus, sfrag, f;
  fagen_attr_s O_ATTR, att;
  fagen_res_s I_RES, r;
  fagen_post_s O_POST, pst;
  int n_mismatch = 0;
  int comparisons = 0;

  fagen_top DUT (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_CE(I_CE), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_DRAW_START(I_DRAW_START), .I_PRIM_DONE(I_PRIM_DONE), .I_PRIM_RESTART(I_PRIM_RESTART),
    .I_FRAG_VALID(frag_valid), .O_FRAG_READY(O_FRAG_READY), .I_FRAG(frag_bus),
    .O_ATTR_VALID(O_ATTR_VALID), .I_ATTR_READY(attr_ready), .O_ATTR(O_ATTR),
    .I_RES_VALID(I_RES_VALID), .O_RES_READY(O_RES_READY), .I_RES(I_RES),
    .O_POST_VALID(O_POST_VALID), .I_POST_READY(I_POST_READY), .O_POST(O_POST));

  fagen_peer peer (.i_clk(I_CLK), .i_srst(I_SRST), .i_send(snd), .i_frag(sfrag),
    .i_stall(stall), .i_frag_ready(O_FRAG_READY), .o_frag_valid(frag_valid),
    .o_frag(frag_bus), .i_attr_valid(O_ATTR_VALID), .o_attr_ready(attr_ready));

  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge I_CLK);
    end while (O_PREADY !== 1'b1);
    rdat = O_PRDATA;
    rerr = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
    @(posedge I_CLK);
  endtask : apb

  task automatic frag(input logic [3:0] st);
    int n;
    sfrag <= f;
    stall <= st;
    snd <= 1'b1;
    @(posedge I_CLK);
    snd <= 1'b0;
    do begin
      @(posedge I_CLK);
    end while (!(frag_valid === 1'b1 && O_FRAG_READY === 1'b1));
    for (n = 1; n < 60; n++) begin
      @(posedge I_CLK);
      if (O_ATTR_VALID === 1'b1) break;
    end
    chk("attr_latency", n, 34);
    att = O_ATTR;
    for (n = 0; n < 20 && !attr_ready; n++) @(posedge I_CLK);
    chk("attr_hold", O_ATTR === att, 1);
  endtask : frag

  task automatic res;
    I_RES <= r;
    I_RES_VALID <= 1'b1;
    do begin
      @(posedge I_CLK);
    end while (O_RES_READY !== 1'b1);
    I_RES_VALID <= 1'b0;
    I_RES <= ~r;
    @(posedge I_CLK);
    chk("post_valid", O_POST_VALID, 1);
    pst = O_POST;
    I_POST_READY <= 1'b1;
    @(posedge I_CLK);
    chk("post_hold", O_POST === pst, 1);
    chk("res_refused", O_RES_READY, 0);
    I_POST_READY <= 1'b0;
    @(posedge I_CLK);
  endtask : res

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    apb(0, REG_CTRL, 0);
    chk("ctrl_rst", rdat, 32'(CTRL_RESET));
    apb(0, REG_HEIGHT, 0);
    chk("height_rst", rdat, 32'h0);
    apb(0, REG_SAMPLES, 0);
    chk("samples_rst", rdat, 32'h1);
    apb(0, REG_STATUS, 0);
    chk("status_idle", rdat, 32'h0);
    apb(0, 12'h014, 0);
    chk("unmapped_err", rerr, 1);
    chk("unmapped_data", rdat, 32'h0);
    apb(1, REG_PRIMCNT, 32'h55);
    apb(0, REG_PRIMCNT, 0);
    chk("primcnt_ro", rdat, 32'h0);
    apb(1, REG_CTRL, 32'h0000fc2f);
    apb(0, REG_CTRL, 0);
    chk("ctrl_rw", rdat, 32'h2f);
    apb(1, REG_CTRL, 32'(CTRL_RESET));
  endtask : t_regs

  task automatic t_coord;
    apb(1, REG_HEIGHT, 32'h64);
    f = '0;
    f.x_w = 16'h0123;
    f.y_w = 16'h0045;
    f.z_w = DEPTH_ONE;
    f.w_c = 32'h00020000;
    f.is_tri = 1'b1;
    f.area_pos = 1'b1;
    f.cov = 8'h0f;
    f.keep = 8'hff;
    f.inv = 8'hff;
    f.sample_num = 3'h3;
    f.spos_x = 9'h040;
    f.spos_y = 9'h0c0;
    frag(4'h0);
    chk("fc_x_def", att.fc_x, 18'h00123);
    chk("fc_y_def", att.fc_y, 18'h00045);
    chk("fc_z_one", att.fc_z, DEPTH_ONE);
    chk("w_recip", att.w_recip, 32'h00008000);
    chk("front_pos", att.front, 1);
    chk("mask_single", att.mask_in, 32'h1);
    chk("sid_single", att.sample_id, 0);
    chk("spos_single", att.spos_x, 9'h080);
    chk("scnt_single", att.sample_cnt, 1);
    apb(1, REG_CTRL, 32'h2f);
    f.z_w = '0;
    frag(4'h3);
    chk("fc_x_int", att.fc_x, 18'h0011b);
    chk("fc_y_ul", att.fc_y, 18'h005f3);
    chk("fc_z_zero", att.fc_z, 0);
    chk("front_rev", att.front, 0);
    f.is_tri = 1'b0;
    frag(4'h0);
    chk("front_nontri", att.front, 1);
  endtask : t_coord

  task automatic t_prim;
    I_DRAW_START <= 1'b1;
    @(posedge I_CLK);
    I_DRAW_START <= 1'b0;
    I_PRIM_DONE <= 1'b1;
    repeat (3) @(posedge I_CLK);
    I_PRIM_DONE <= 1'b0;
    I_PRIM_RESTART <= 1'b1;
    @(posedge I_CLK);
    I_PRIM_RESTART <= 1'b0;
    @(posedge I_CLK);
    apb(0, REG_PRIMCNT, 0);
    chk("primcnt", rdat, 32'h3);
    // clock enable low must freeze the counter
    I_CE <= 1'b0;
    I_PRIM_DONE <= 1'b1;
    @(posedge I_CLK);
    I_CE <= 1'b1;
    I_PRIM_DONE <= 1'b0;
    apb(0, REG_PRIMCNT, 0);
    chk("ce_freeze", rdat, 32'h3);
    f.gs_prim = 32'h0000abcd;
    frag(4'h0);
    chk("prim_cnt_idx", att.prim_idx, 32'h3);
    apb(1, REG_CTRL, 32'h38);
    frag(4'h0);
    chk("prim_gs_idx", att.prim_idx, 32'h0000abcd);
    I_DRAW_START <= 1'b1;
    I_PRIM_DONE <= 1'b1;
    @(posedge I_CLK);
    I_DRAW_START <= 1'b0;
    I_PRIM_DONE <= 1'b0;
    @(posedge I_CLK);
    apb(0, REG_PRIMCNT, 0);
    chk("primcnt_clr", rdat, 32'h0);
  endtask : t_prim

  task automatic t_mask;
    apb(1, REG_SAMPLES, 32'h4);
    apb(1, REG_CTRL, 32'h28);
    f.cov = 8'h0f;
    f.keep = 8'h0d;
    f.inv = 8'h07;
    f.sample_num = 3'h2;
    frag(4'h0);
    chk("mask_ms", att.mask_in, 32'h05);
    chk("sid_ms", att.sample_id, 2);
    chk("spos_ms", att.spos_y, 9'h0c0);
    chk("scnt_ms", att.sample_cnt, 4);
    apb(1, REG_CTRL, 32'ha8);
    frag(4'h0);
    chk("mask_persample", att.mask_in, 32'h04);
    apb(1, REG_CTRL, 32'h20);
    frag(4'h0);
    chk("mask_msoff", att.mask_in, 32'h1);
    chk("sid_msoff", att.sample_id, 0);
    chk("spos_msoff", att.spos_y, 9'h080);
    chk("scnt_msoff", att.sample_cnt, 4);
    f.cov = 8'h00;
    frag(4'h0);
    chk("mask_uncov", att.mask_in, 32'h0);
  endtask : t_mask

  task automatic t_post;
    apb(1, REG_CTRL, 32'h68);
    r = '0;
    r.depth = 32'h02000000;
    r.cov_out = 32'hff;
    r.mask_in = 32'h05;
    r.color = {4{32'h12345678}};
    res();
    chk("depth_fix_hi", pst.depth, 25'h0ffffff);
    chk("cov_and", pst.cov, 32'h05);
    chk("col_pass", pst.color[0], 32'h12345678);
    r.depth = 32'hff000000;
    r.cov_out = 32'hf0;
    r.mask_in = 32'h3c;
    res();
    chk("depth_neg", pst.depth, 25'h0);
    chk("cov_drop", pst.cov, 32'h30);
    apb(1, REG_CTRL, 32'h148);
    r.depth = 32'h02000000;
    r.color = {4{32'h00008000}};
    res();
    chk("depth_flt", pst.depth, DEPTH_ONE);
    chk("col_unorm", pst.color[3], 32'h80);
    apb(1, REG_CTRL, 32'h248);
    r.color = {4{32'hffff8000}};
    res();
    chk("col_snorm", pst.color[1], 32'hffffffc0);
    apb(1, REG_CTRL, 32'h208);
    r.rast_depth = 25'h0abcdef;
    res();
    chk("depth_rast", pst.depth, 25'h0abcdef);
  endtask : t_post

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    I_SRST = 1'b1;
    I_CE = 1'b1;
    I_PSEL = 1'b0;
    I_PENABLE = 1'b0;
    I_PWRITE = 1'b0;
    I_PADDR = '0;
    I_PWDATA = '0;
    I_DRAW_START = 1'b0;
    I_PRIM_DONE = 1'b0;
    I_PRIM_RESTART = 1'b0;
    I_RES_VALID = 1'b0;
    I_RES = '0;
    I_POST_READY = 1'b0;
    snd = 1'b0;
    sfrag = '0;
    stall = 4'h0;
    repeat (3) @(posedge I_CLK);
    I_SRST <= 1'b0;
    t_regs();
    t_coord();
    t_prim();
    t_mask();
    t_post();
    print_verdict();
  end

  initial begin
    repeat (6000) @(posedge I_CLK);
    n_mismatch++;
    print_verdict();
  end
endmodule : fagen_top_tb
